// ---- rtl/ssp_pkg.sv ----
// Shared constants for the serial port pin block
package ssp_pkg;
    // Pin positions within the six-bit pin vectors
    localparam int SSP_NPINS = 6;
    localparam int SSP_PIN_A = 0;
    localparam int SSP_PIN_B = 1;
    localparam int SSP_PIN_FS = 2;
    localparam int SSP_PIN_CK = 3;
    localparam int SSP_PIN_RX = 4;
    localparam int SSP_PIN_TX = 5;
    // Transmit lanes: lane 0 on the data pin, lanes 1 and 2 on the control pins
    localparam int SSP_NLANES = 3;
    localparam int SSP_WORD_W = 16;
    // System clock cycles in each half of the generated bit clock
    localparam int SSP_HALF_DIV = 4;
    // Least system clock cycles inside each bit clock half
    localparam int SSP_MIN_HALF = 3;
    // Least ratio of system clock to serial clock frequency
    localparam int SSP_MIN_RATIO = 3;
    // Reset values: every pin is a general-purpose input
    localparam logic [5:0] SSP_DIR_RST = 6'h00;
    localparam logic [5:0] SSP_FSEL_RST = 6'h00;
    localparam logic [5:0] SSP_GOUT_RST = 6'h00;
endpackage

// ---- rtl/ssp_rx_if.sv ----
// Carrier between the system-side pin logic and the link-side receiver
`timescale 1ns/1ps
interface ssp_rx_if #(
    parameter int W = 16
);
    logic rx_bit;
    logic rx_fs;
    logic en;
    logic [W-1:0] word;
    logic tgl;
    modport link (input rx_bit, input rx_fs, input en, output word, output tgl);
    modport sys (output rx_bit, output rx_fs, output en, input word, input tgl);
endinterface

// ---- rtl/ssp_rx_link.sv ----
// Receive shifter running on the link's own bit clock
`timescale 1ns/1ps
module ssp_rx_link
    import ssp_pkg::*;
#(
    parameter int W = SSP_WORD_W
) (
    input wire logic lclk_i,
    input wire logic rst_i,
    ssp_rx_if.link rxl
);
    localparam int CW = $clog2(W);

    typedef struct packed {
        logic rs1;
        logic rs2;
        logic en1;
        logic en2;
        logic fs_d;
        logic busy;
        logic [CW-1:0] cnt;
        logic [W-1:0] sh;
        logic [W-1:0] word;
        logic tgl;
    } ssp_lnk_t;

    ssp_lnk_t st_r;
    ssp_lnk_t st_nxt;

    // Frame sync marks the bit before the first data bit; word is handed over by a toggle
    always_comb begin
        st_nxt = st_r;
        st_nxt.rs1 = rst_i;
        st_nxt.rs2 = st_r.rs1;
        st_nxt.en1 = rxl.en;
        st_nxt.en2 = st_r.en1;
        st_nxt.fs_d = rxl.rx_fs;
        if (!st_r.en2) begin
            st_nxt.busy = 1'b0;
        end else if (!st_r.busy) begin
            if (rxl.rx_fs && !st_r.fs_d) begin
                st_nxt.busy = 1'b1;
                st_nxt.cnt = '0;
            end
        end else begin
            st_nxt.sh = {st_r.sh[W-2:0], rxl.rx_bit};
            if (st_r.cnt == CW'(W-1)) begin
                st_nxt.word = {st_r.sh[W-2:0], rxl.rx_bit};
                st_nxt.tgl = !st_r.tgl;
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
        // Reset arrives through two flops; the link clock must run during it
        if (st_r.rs2) begin
            st_nxt = '0;
            st_nxt.rs1 = rst_i;
            st_nxt.rs2 = st_r.rs1;
        end
    end

    always_ff @(posedge lclk_i) begin
        st_r <= st_nxt;
    end

    assign rxl.word = st_r.word;
    assign rxl.tgl = st_r.tgl;

    // word handed over only after a full count
    rx_word_done_a: assert property (@(posedge lclk_i) disable iff (st_r.rs2)
        $changed(st_r.tgl) |-> $past(st_r.busy) && $past(st_r.cnt) == CW'(W-1))
        else $error("receive word finished early");
    rx_enable_gate_a: assert property (@(posedge lclk_i) disable iff (st_r.rs2)
        !st_r.en2 |=> !st_r.busy)
        else $error("receiver busy while disabled");
    rx_word_c: cover property (@(posedge lclk_i) disable iff (st_r.rs2) $changed(st_r.tgl));
endmodule

// ---- rtl/ssp_pins.sv ----
// Pin functions, general-purpose I/O and transmit framing of the serial port
`timescale 1ns/1ps
// What this block does
// - Async: control pin A is receive clock
// - Sync: pin A is lane 1 or flag 0
// - Async: control pin B is receive frame sync
// - Sync: pin B is lane 2 or flag 1
// - Frame sync pin frames transmitter, receiver if sync
// - Frame sync output internal, input from partner
// - Bit clock pin clocks transmitter, receiver if sync
// - Receive pin is input, bits shift in
// - Transmit pin drives while a word shifts
// - After reset all pins general-purpose
// - General-purpose pin direction follows direction setting
// - Function select hands pin to serial port
module ssp_pins
    import ssp_pkg::*;
#(
    parameter int W = SSP_WORD_W,
    parameter int HALF_DIV = SSP_HALF_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lclk_i,
    input wire logic [SSP_NPINS-1:0] pins_i,
    output logic [SSP_NPINS-1:0] pins_o,
    output logic [SSP_NPINS-1:0] pins_oe_o,
    input wire logic cfg_wr_i,
    input wire logic [SSP_NPINS-1:0] port_direction_setting_i,
    input wire logic [SSP_NPINS-1:0] port_function_select_i,
    input wire logic [SSP_NPINS-1:0] gpio_data_i,
    output logic [SSP_NPINS-1:0] gpio_in_o,
    input wire logic sync_mode_i,
    input wire logic clk_out_i,
    input wire logic fs_out_i,
    input wire logic rxclk_out_i,
    input wire logic rxfs_out_i,
    input wire logic [1:0] flag_sel_i,
    input wire logic [1:0] flag_dir_i,
    input wire logic [1:0] flag_out_i,
    output logic [1:0] flag_in_o,
    input wire logic tx_en_i,
    input wire logic [SSP_NLANES-1:0][W-1:0] tx_word_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic tx_busy_o,
    input wire logic rx_en_i,
    output logic [W-1:0] rx_word_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic rx_overrun_o,
    input wire logic rx_ovr_clr_i
);
    localparam int CW = $clog2(W);
    localparam int DW = $clog2(HALF_DIV);

    // Refuse settings the framing or the edge detection cannot serve
    if (W < 2) begin : g_chk_w
        $error("word width must be at least two");
    end
    if (HALF_DIV < SSP_MIN_HALF || 2 * HALF_DIV < SSP_MIN_RATIO) begin : g_chk_div
        $error("bit clock half too short");
    end

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } ssp_tx_st_t;

    typedef struct packed {
        logic [SSP_NPINS-1:0] dir;
        logic [SSP_NPINS-1:0] fsel;
        logic [SSP_NPINS-1:0] gout;
        logic [SSP_NPINS-1:0] pin_s1;
        logic [SSP_NPINS-1:0] pin_s2;
        logic ck_d;
        logic [DW-1:0] div;
        logic ick;
        logic [CW-1:0] fcnt;
        logic ifs;
        ssp_tx_st_t txs;
        logic [CW-1:0] cnt;
        logic [SSP_NLANES-1:0][W-1:0] sh;
        logic [SSP_NLANES-1:0][W-1:0] hold;
        logic hold_v;
        logic tg_s1;
        logic tg_s2;
        logic tg_d;
        logic pend;
        logic [W-1:0] pword;
        logic [1:0][W-1:0] fifo;
        logic wp;
        logic rp;
        logic [1:0] fcount;
        logic ovr;
    } ssp_st_t;

    ssp_st_t st_r;
    ssp_st_t st_nxt;
    ssp_rx_if #(.W(W)) rxl ();

    logic int_tick;
    logic bclk_rise;
    logic fs_lvl;
    logic new_word;
    logic push;
    logic pop;
    logic tx_on;

    // Generated clock ticks only while transmission is enabled
    assign int_tick = clk_out_i && tx_en_i && st_r.div == DW'(HALF_DIV - 1);
    // one bit clock serves the transmitter
    // partner clock edge seen only after two flops
    assign bclk_rise = clk_out_i ? (int_tick && !st_r.ick)
                                 : (st_r.pin_s2[SSP_PIN_CK] && !st_r.ck_d);
    // transmit framing always from the frame sync pin
    // own sync when output, partner's when input
    assign fs_lvl = fs_out_i ? st_r.ifs : st_r.pin_s2[SSP_PIN_FS];
    assign new_word = st_r.tg_s2 ^ st_r.tg_d;
    assign push = st_r.pend && st_r.fcount != 2'h2;
    assign pop = rx_ready_i && st_r.fcount != 2'h0;
    assign tx_on = st_r.txs == TX_SHIFT;

    // Receiver gets raw pin levels; it samples them on the link clock itself
    assign rxl.rx_bit = pins_i[SSP_PIN_RX];
    // async receive sync on pin B, else shared sync
    assign rxl.rx_fs = sync_mode_i ? pins_i[SSP_PIN_FS] : pins_i[SSP_PIN_B];
    assign rxl.en = rx_en_i && st_r.fsel[SSP_PIN_RX];

    ssp_rx_link #(.W(W)) u_rx (
        .lclk_i(lclk_i),
        .rst_i(rst_i),
        .rxl(rxl)
    );

    // Next state of every register in the block
    always_comb begin
        st_nxt = st_r;
        // two flops before any pin is read on the system clock
        st_nxt.pin_s1 = pins_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.ck_d = st_r.pin_s2[SSP_PIN_CK];
        // function and direction loaded by strobe
        if (cfg_wr_i) begin
            st_nxt.dir = port_direction_setting_i;
            st_nxt.fsel = port_function_select_i;
            st_nxt.gout = gpio_data_i;
        end
        // Bit clock divider; held low when unused so the pin idles quiet
        if (clk_out_i && tx_en_i) begin
            if (int_tick) begin
                st_nxt.div = '0;
                st_nxt.ick = !st_r.ick;
            end else begin
                st_nxt.div = st_r.div + 1'b1;
            end
        end else begin
            st_nxt.div = '0;
            st_nxt.ick = 1'b0;
        end
        // internal frame sync, one bit wide per word
        if (!tx_en_i) begin
            st_nxt.fcnt = CW'(W - 1);
            st_nxt.ifs = 1'b0;
        end else if (clk_out_i && bclk_rise) begin
            st_nxt.fcnt = (st_r.fcnt == CW'(W - 1)) ? '0 : st_r.fcnt + 1'b1;
            st_nxt.ifs = st_r.fcnt == CW'(W - 1);
        end
        // Holding register decouples the user from frame timing
        if (!st_r.hold_v && tx_valid_i) begin
            st_nxt.hold = tx_word_i;
            st_nxt.hold_v = 1'b1;
        end
        // shift out, sync seen on the edge before the first bit
        unique case (st_r.txs)
            TX_IDLE: begin
                if (bclk_rise && fs_lvl && st_r.hold_v) begin
                    st_nxt.sh = st_r.hold;
                    st_nxt.hold_v = 1'b0;
                    st_nxt.cnt = CW'(W - 1);
                    st_nxt.txs = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (bclk_rise) begin
                    if (st_r.cnt != '0) begin
                        for (int l = 0; l < SSP_NLANES; l++) begin
                            st_nxt.sh[l] = {st_r.sh[l][W-2:0], 1'b0};
                        end
                        st_nxt.cnt = st_r.cnt - 1'b1;
                    end else if (fs_lvl && st_r.hold_v) begin
                        st_nxt.sh = st_r.hold;
                        st_nxt.hold_v = 1'b0;
                        st_nxt.cnt = CW'(W - 1);
                    end else begin
                        st_nxt.txs = TX_IDLE;
                    end
                end
            end
            default: st_nxt.txs = TX_IDLE;
        endcase
        if (!tx_en_i) begin
            st_nxt.txs = TX_IDLE;
        end
        // Word toggle from the link domain, then two-entry buffer
        st_nxt.tg_s1 = rxl.tgl;
        st_nxt.tg_s2 = st_r.tg_s1;
        st_nxt.tg_d = st_r.tg_s2;
        if (push) begin
            st_nxt.fifo[st_r.wp] = st_r.pword;
            st_nxt.wp = !st_r.wp;
            st_nxt.pend = 1'b0;
        end
        if (pop) begin
            st_nxt.rp = !st_r.rp;
        end
        st_nxt.fcount = st_r.fcount + 2'(push) - 2'(pop);
        // Clear first so a fresh overrun in the same cycle survives
        if (rx_ovr_clr_i) begin
            st_nxt.ovr = 1'b0;
        end
        // Link cannot be stalled: a word finding the pending slot and the two-entry buffer both full is lost
        if (new_word) begin
            if (st_r.pend && !push) begin
                st_nxt.ovr = 1'b1;
            end else begin
                st_nxt.pend = 1'b1;
                st_nxt.pword = rxl.word;
            end
        end
        // all pins general-purpose inputs after reset
        if (rst_i) begin
            st_nxt = '0;
            st_nxt.dir = SSP_DIR_RST;
            st_nxt.fsel = SSP_FSEL_RST;
            st_nxt.gout = SSP_GOUT_RST;
            st_nxt.txs = TX_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    // Pin drive: general-purpose first, serial function where selected
    always_comb begin
        pins_o = st_r.gout;
        pins_oe_o = st_r.dir;
        for (int k = 0; k < 2; k++) begin
            if (st_r.fsel[SSP_PIN_A + k]) begin
                if (!sync_mode_i) begin
                    // pin B carries receive frame sync
                    pins_o[SSP_PIN_A + k] = (k == 0) ? st_r.ick : st_r.ifs;
                    pins_oe_o[SSP_PIN_A + k] = (k == 0) ? rxclk_out_i : rxfs_out_i;
                end else if (flag_sel_i[k]) begin
                    pins_o[SSP_PIN_A + k] = flag_out_i[k];
                    pins_oe_o[SSP_PIN_A + k] = flag_dir_i[k];
                end else begin
                    pins_o[SSP_PIN_A + k] = st_r.sh[k + 1][W-1];
                    pins_oe_o[SSP_PIN_A + k] = tx_on;
                end
            end
        end
        // frame sync pin driven only as output
        if (st_r.fsel[SSP_PIN_FS]) begin
            pins_o[SSP_PIN_FS] = st_r.ifs;
            pins_oe_o[SSP_PIN_FS] = fs_out_i;
        end
        // bit clock pin driven only as output
        if (st_r.fsel[SSP_PIN_CK]) begin
            pins_o[SSP_PIN_CK] = st_r.ick;
            pins_oe_o[SSP_PIN_CK] = clk_out_i;
        end
        if (st_r.fsel[SSP_PIN_RX]) begin
            pins_o[SSP_PIN_RX] = 1'b0;
            pins_oe_o[SSP_PIN_RX] = 1'b0;
        end
        // transmit pin drives only during a word
        if (st_r.fsel[SSP_PIN_TX]) begin
            pins_o[SSP_PIN_TX] = st_r.sh[0][W-1];
            pins_oe_o[SSP_PIN_TX] = tx_on;
        end
    end

    assign gpio_in_o = st_r.pin_s2;
    assign flag_in_o = {st_r.pin_s2[SSP_PIN_B], st_r.pin_s2[SSP_PIN_A]};
    assign tx_ready_o = !st_r.hold_v;
    assign tx_busy_o = tx_on;
    assign rx_word_o = st_r.fifo[st_r.rp];
    assign rx_valid_o = st_r.fcount != 2'h0;
    assign rx_overrun_o = st_r.ovr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    gpio_reset_a: assert property (disable iff (1'b0) rst_i |=> pins_oe_o == '0 && st_r.fsel == '0)
        else $error("pin driven after reset");
    gpio_dir_a: assert property (((pins_oe_o ^ st_r.dir) & ~st_r.fsel) == '0)
        else $error("gpio direction mismatch");
    func_sel_a: assert property (cfg_wr_i ##1 !cfg_wr_i |-> st_r.fsel == $past(port_function_select_i))
        else $error("function select not taken");
    rx_pin_in_a: assert property (st_r.fsel[SSP_PIN_RX] |-> !pins_oe_o[SSP_PIN_RX])
        else $error("receive pin driven");
    tx_pin_drive_a: assert property (st_r.fsel[SSP_PIN_TX] |-> pins_oe_o[SSP_PIN_TX] == tx_on)
        else $error("transmit pin drive wrong");
    async_rxclk_a: assert property (st_r.fsel[SSP_PIN_A] && !sync_mode_i && rxclk_out_i
        |-> pins_oe_o[SSP_PIN_A] && pins_o[SSP_PIN_A] == st_r.ick)
        else $error("receive clock not on pin A");
    sync_flag_a: assert property (st_r.fsel[SSP_PIN_B] && sync_mode_i && flag_sel_i[1]
        |-> pins_o[SSP_PIN_B] == flag_out_i[1] && pins_oe_o[SSP_PIN_B] == flag_dir_i[1])
        else $error("flag 1 not on pin B");
    ext_edge_a: assert property ((!clk_out_i)[*3] ##0 $rose(pins_i[SSP_PIN_CK])
        ##1 (pins_i[SSP_PIN_CK] && !clk_out_i)[*2] |-> bclk_rise)
        else $error("partner clock edge missed");
    frame_len_a: assert property (clk_out_i && tx_en_i && $rose(tx_on)
        |-> (tx_on && tx_en_i)[*8])
        else $error("word shift ended early");
    ovr_set_a: assert property (new_word && st_r.pend && !push |=> st_r.ovr)
        else $error("overrun not flagged");
    tx_start_c: cover property ($rose(tx_on));
    rx_pop_c: cover property (pop);
    ovr_c: cover property ($rose(st_r.ovr));
    async_c: cover property (!sync_mode_i && st_r.fsel[SSP_PIN_A] && rxclk_out_i && st_r.ick);
endmodule

// ---- test/ssp_partner.sv ----
// Far-side codec model: receive clock, frame sync and data on the port's pins
`timescale 1ns/1ps
module ssp_partner (
    output logic [5:0] drv_o
);
    initial drv_o = 6'h00;

    // Static levels on every line the block does not drive
    task automatic hold(input logic [5:0] v);
        drv_o = v;
    endtask

    // Free clock on control pin A so the link side sees its reset or a new enable
    task automatic burst(input int n);
        repeat (n) begin
            #32 drv_o[0] = 1'b1;
            #32 drv_o[0] = 1'b0;
        end
    endtask

    // slow bit clock on its own pin: each 200 ns half spans four system cycles
    // frame sync high across the first rise only, changed while the clock is low
    task automatic clk_tx(input int n);
        for (int i = 0; i < n; i++) begin
            drv_o[2] = (i == 0);
            #200 drv_o[3] = 1'b1;
            #200 drv_o[3] = 1'b0;
        end
    endtask

    // sync, clock then data
    // Sync high across the bit before the word, data MSB first, changed on the falling clock
    // The clock stands still low between frames; the data line then shows the inverse of its last bit
    task automatic send(input logic [15:0] w);
        drv_o[1] = 1'b1;
        #32 drv_o[0] = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            #32 drv_o[0] = 1'b0;
            drv_o[1] = 1'b0;
            drv_o[4] = w[i];
            #32 drv_o[0] = 1'b1;
        end
        #32 drv_o[0] = 1'b0;
        drv_o[4] = ~w[0];
    endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the serial port pin block
`timescale 1ns/1ps
module tb_top
    import ssp_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic lclk_i, cfg_wr_i, sync_mode_i, clk_out_i, fs_out_i, rxclk_out_i, rxfs_out_i, tx_en_i, tx_valid_i;
    logic tx_ready_o, tx_busy_o, rx_en_i, rx_valid_o, rx_ready_i, rx_overrun_o, rx_ovr_clr_i;
    logic [1:0] flag_sel_i, flag_dir_i, flag_out_i, flag_in_o;
    logic [5:0] pins_i, pins_o, pins_oe_o, port_direction_setting_i, port_function_select_i;
    logic [5:0] gpio_data_i, gpio_in_o, pdrv, d, g, h;
    logic [2:0][15:0] tx_word_i;
    logic [15:0] rx_word_o;
    logic [15:0] rxw [4] = '{16'hc001, 16'h5a5a, 16'h8000, 16'h0001};
    logic [31:0] sh0, sh1, sh2;
    int ncap = 0;
    int oe_bad = 0;
    int failures = 0;
    int checked = 0;
    int cyc = 0;

    always #25 clk_i = ~clk_i;
    // Wire level: the block wins where it drives, the partner elsewhere
    assign pins_i = (pins_oe_o & pins_o) | (~pins_oe_o & pdrv);
    // Receive clock is the bit clock pin in sync mode, control pin A otherwise
    assign lclk_i = sync_mode_i ? pins_i[3] : pins_i[0];

    ssp_pins ssp_pins_inst (.clk_i, .rst_i, .lclk_i, .pins_i, .pins_o, .pins_oe_o, .cfg_wr_i,
        .port_direction_setting_i, .port_function_select_i, .gpio_data_i, .gpio_in_o, .sync_mode_i,
        .clk_out_i, .fs_out_i, .rxclk_out_i, .rxfs_out_i, .flag_sel_i, .flag_dir_i, .flag_out_i, .flag_in_o,
        .tx_en_i, .tx_word_i, .tx_valid_i, .tx_ready_o, .tx_busy_o, .rx_en_i, .rx_word_o, .rx_valid_o,
        .rx_ready_i, .rx_overrun_o, .rx_ovr_clr_i);
    ssp_partner ssp_partner_inst (.drv_o(pdrv));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Settings load on the strobe; one spare cycle lets the pin mux settle
    task automatic cfg(input logic [5:0] dd, input logic [5:0] ff, input logic [5:0] gg);
        @(negedge clk_i);
        {port_direction_setting_i, port_function_select_i, gpio_data_i, cfg_wr_i} = {dd, ff, gg, 1'b1};
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic push(input logic [2:0][15:0] w);
        int n = 0;
        while (tx_ready_o !== 1'b1 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        chk("tx_ready", 1, tx_ready_o);
        tx_word_i = w;
        tx_valid_i = 1'b1;
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask

    task automatic wait_cap(input int bits);
        int n = 0;
        while (ncap < bits && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        cyc_n(40);
    endtask

    task automatic pop(input logic [15:0] w);
        int n = 0;
        while (rx_valid_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        chk("rx_word", w, rx_word_o);
        rx_ready_i = 1'b1;
        @(negedge clk_i);
        rx_ready_i = 1'b0;
    endtask

    // Bits sampled mid-bit on the falling bit clock while a word shifts
    always @(negedge pins_i[3]) begin
        #1;
        if (tx_busy_o === 1'b1) begin
            sh0 = {sh0[30:0], pins_i[5]};
            sh1 = {sh1[30:0], pins_i[0]};
            sh2 = {sh2[30:0], pins_i[1]};
            ncap++;
            if (pins_oe_o[5] !== 1'b1) begin
                oe_bad++;
            end
        end
    end

    // A hang ends the run as a mismatch
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        {cfg_wr_i, sync_mode_i, clk_out_i, fs_out_i, rxclk_out_i, rxfs_out_i, tx_en_i, tx_valid_i} = '0;
        {rx_en_i, rx_ready_i, rx_ovr_clr_i, flag_sel_i, flag_dir_i, flag_out_i} = '0;
        {port_direction_setting_i, port_function_select_i, gpio_data_i, tx_word_i} = '0;
        {sh0, sh1, sh2} = '0;
        // Link side needs its clock running while reset is held
        fork
            ssp_partner_inst.burst(15);
            cyc_n(20);
        join
        rst_i = 1'b0;
        chk("oe_rst", 6'h00, pins_oe_o);
        chk("ready_rst", 1, tx_ready_o);
        chk("rx_rst", 0, {rx_valid_o, rx_overrun_o});
        // Two complementary direction patterns
        for (int i = 0; i < 2; i++) begin
            d = i ? 6'h15 : 6'h2a;
            g = i ? 6'h00 : 6'h3f;
            h = i ? 6'h2a : 6'h15;
            ssp_partner_inst.hold(h);
            cfg(d, 6'h00, g);
            chk("oe_gpio", d, pins_oe_o);
            chk("out_gpio", d & g, pins_o & pins_oe_o);
            cyc_n(3);
            chk("in_gpio", (d & g) | (~d & h), gpio_in_o);
        end
        cfg(6'h3f, 6'h10, 6'h00);
        chk("oe_fsel", 6'h2f, pins_oe_o);
        {sync_mode_i, clk_out_i, fs_out_i, flag_sel_i, flag_dir_i, flag_out_i} = 9'b111111101;
        cfg(6'h00, 6'h3f, 6'h00);
        chk("oe_sync", 4'hf, pins_oe_o[3:0]);
        chk("flag_out", 2'b01, pins_o[1:0]);
        {fs_out_i, flag_dir_i} = 3'b000;
        ssp_partner_inst.hold(6'h02);
        cyc_n(4);
        chk("oe_in", 3'b000, pins_oe_o[2:0]);
        chk("flag_in", 2'b10, flag_in_o);
        // Three lanes, two words back to back
        {fs_out_i, flag_sel_i, tx_en_i} = 4'b1001;
        ncap = 0;
        push({16'hfedc, 16'h1234, 16'ha5c3});
        push({16'h7ffe, 16'h8001, 16'h0f1e});
        wait_cap(32);
        chk("lane0", 32'ha5c30f1e, sh0);
        chk("lane1", 32'h12348001, sh1);
        chk("lane2", 32'hfedc7ffe, sh2);
        chk("bits", 32, ncap);
        chk("oe_tx", 0, oe_bad);
        tx_en_i = 1'b0;
        {sync_mode_i, rxclk_out_i, rxfs_out_i} = 3'b011;
        cyc_n(2);
        chk("oe_async", 4'hf, pins_oe_o[3:0]);
        tx_en_i = 1'b1;
        ncap = 0;
        push({16'h0000, 16'h0000, 16'h9c31});
        wait_cap(16);
        chk("async_tx", 16'h9c31, sh0[15:0]);
        chk("bits_async", 16, ncap);
        // Partner supplies bit clock and frame sync; lanes 0 and 1 shift on its rises
        {sync_mode_i, clk_out_i, fs_out_i} = 3'b100;
        cyc_n(4);
        ncap = 0;
        push({16'h0000, 16'hd4e1, 16'h6b2d});
        ssp_partner_inst.clk_tx(17);
        wait_cap(16);
        chk("ext_tx", 32'h6b2dd4e1, {sh0[15:0], sh1[15:0]});
        chk("bits_ext", 16, ncap);
        // Receive four words unread: two buffered, one pending, one lost
        {sync_mode_i, tx_en_i, rxclk_out_i, rxfs_out_i, rx_en_i} = 5'b00001;
        ssp_partner_inst.hold(6'h00);
        // Receiver enable crosses on the link clock, so it needs edges before the first frame
        ssp_partner_inst.burst(3);
        cyc_n(4);
        chk("oe_rx", 3'b000, {pins_oe_o[4], pins_oe_o[1:0]});
        for (int i = 0; i < 4; i++) begin
            ssp_partner_inst.send(rxw[i]);
        end
        cyc_n(20);
        chk("overrun", 1, rx_overrun_o);
        for (int i = 0; i < 3; i++) begin
            pop(rxw[i]);
        end
        cyc_n(2);
        chk("empty", 0, rx_valid_o);
        rx_ovr_clr_i = 1'b1;
        cyc_n(1);
        rx_ovr_clr_i = 1'b0;
        cyc_n(1);
        chk("ovr_clr", 0, rx_overrun_o);
        finish_test();
    end
endmodule
